// [logic/smac_top.sv]
// register-space access checker: cpu and copy machine requests, own security registers
// assumes requesters are on clk; verdict appears one enabled edge after the request
`timescale 1ns/1ns
`include "smac_cfg.svh"

module smac_top
    import smac_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // cpu side
    input wire smac_req_t cpu_req,
    input wire smac_mode_t cpu_mode,
    input wire logic seg_hw_rd,
    input wire logic seg_hw_wr,
    input wire logic [7:0] ext_rdata,
    output smac_ans_t cpu_ans,
    output logic ext_we,
    output logic cpu_exception,
    // segment table write check
    input wire logic tbl_wr_req,
    input wire logic tbl_seg_writable,
    output logic tbl_wr_ok,
    // copy machine side
    input wire logic cm_start,
    input wire logic cm_done,
    input wire smac_req_t cm_req,
    output smac_ans_t cm_ans,
    output logic cm_busy,
    // security state
    output logic [15:0] seg_tbl_addr,
    output logic seg_enable,
    output logic [15:0] fw_rights
);

    logic cpu_grant;
    smac_group_t cpu_group;
    logic cm_grant;
    smac_mode_t cm_mode_d, cm_mode_q;
    smac_cm_state_t cm_state_d, cm_state_q;
    logic [15:0] seg_d, seg_q;
    logic [7:0] fwl_d, fwl_q, fwh_d, fwh_q;
    smac_ans_t cpu_ans_d, cpu_ans_q, cm_ans_d, cm_ans_q;
    logic ext_we_d, ext_we_q;
    logic tbl_ok_d, tbl_ok_q;
    logic seg_en_d, seg_en_q;
    logic [7:0] own_rdata;
    logic own_hit;

    ////////////////////////////////////////////////////////////////////////////
    // permission checks, one per requester
    smac_check u_cpu_check (
        .addr(cpu_req.addr),
        .is_write(cpu_req.wr),
        .mode(cpu_mode),
        .fw_rights({fwh_q, fwl_q}),
        .seg_rd(seg_hw_rd),
        .seg_wr(seg_hw_wr),
        .grant(cpu_grant),
        .group(cpu_group)
    );

    // the copy machine is judged by its latched mode, never the live one
    smac_check u_cm_check (
        .addr(cm_req.addr),
        .is_write(cm_req.wr),
        .mode(cm_mode_q),
        .fw_rights({fwh_q, fwl_q}),
        .seg_rd(seg_hw_rd),
        .seg_wr(seg_hw_wr),
        .grant(cm_grant),
        .group()
    );

    ////////////////////////////////////////////////////////////////////////////
    // copy machine mode latch
    always_comb begin
        cm_state_d = cm_state_q;
        cm_mode_d = cm_mode_q;
        case (cm_state_q)
            SMAC_CM_IDLE: begin
                if (cm_start) begin
                    cm_state_d = SMAC_CM_RUN;
                    cm_mode_d = cpu_mode;
                end
            end
            SMAC_CM_RUN: begin
                if (cm_done) begin
                    cm_state_d = SMAC_CM_IDLE;
                end
            end
            default: begin
                cm_state_d = SMAC_CM_IDLE;
            end
        endcase
    end

    // mode resets to boot and keeps the last latched one after done, unused while idle; requests while idle are refused
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cm_state_q <= SMAC_CM_IDLE;
            cm_mode_q <= SMAC_MODE_BOOT;
        end else if (ce) begin
            cm_state_q <= cm_state_d;
            cm_mode_q <= cm_mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // own security registers; reset values are constants with no override path
    always_comb begin
        own_hit = 1'b1;
        case (cpu_req.addr)
            `SMAC_ADDR_SEG_TBL_LO: own_rdata = seg_q[7:0];
            `SMAC_ADDR_SEG_TBL_HI: own_rdata = seg_q[15:8];
            `SMAC_ADDR_FW_LOW: own_rdata = fwl_q;
            `SMAC_ADDR_FW_HIGH: own_rdata = fwh_q;
            `SMAC_ADDR_MODE_STATUS: own_rdata = {5'h00, cpu_mode};
            default: begin
                own_hit = 1'b0;
                own_rdata = `SMAC_RST_DATA;
            end
        endcase
        seg_d = seg_q;
        fwl_d = fwl_q;
        fwh_d = fwh_q;
        // only a granted cpu write lands; mode status follows cpu_mode and is never written
        if (cpu_req.valid && cpu_req.wr && cpu_grant) begin
            case (cpu_req.addr)
                `SMAC_ADDR_SEG_TBL_LO: seg_d = {seg_q[15:8], cpu_req.wdata};
                `SMAC_ADDR_SEG_TBL_HI: seg_d = {cpu_req.wdata, seg_q[7:0]};
                `SMAC_ADDR_FW_LOW: fwl_d = cpu_req.wdata;
                `SMAC_ADDR_FW_HIGH: fwh_d = cpu_req.wdata;
                default: begin
                    seg_d = seg_q;
                end
            endcase
        end
        seg_en_d = (seg_d != `SMAC_RST_SEG_TBL);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seg_q <= `SMAC_RST_SEG_TBL;
            fwl_q <= `SMAC_RST_FW_RIGHTS;
            fwh_q <= `SMAC_RST_FW_RIGHTS;
            seg_en_q <= 1'b0;
        end else if (ce) begin
            seg_q <= seg_d;
            fwl_q <= fwl_d;
            fwh_q <= fwh_d;
            seg_en_q <= seg_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // verdicts; refused reads return zero so nothing leaks on a fault
    always_comb begin
        cpu_ans_d.valid = cpu_req.valid;
        cpu_ans_d.grant = cpu_req.valid && cpu_grant;
        cpu_ans_d.fault = cpu_req.valid && !cpu_grant;
        cpu_ans_d.rdata = `SMAC_RST_DATA;
        if (cpu_req.valid && !cpu_req.wr && cpu_grant) begin
            cpu_ans_d.rdata = own_hit ? own_rdata : ext_rdata;
        end
        ext_we_d = cpu_req.valid && cpu_req.wr && cpu_grant && !own_hit;
        cm_ans_d.valid = cm_req.valid;
        cm_ans_d.grant = cm_req.valid && cm_grant && cm_state_q == SMAC_CM_RUN;
        cm_ans_d.fault = cm_req.valid && !cm_ans_d.grant;
        cm_ans_d.rdata = `SMAC_RST_DATA; // copy data path is outside this block
        // user table writes hinge on the segment rights of the table location
        tbl_ok_d = tbl_wr_req && (cpu_mode != SMAC_MODE_USER || tbl_seg_writable);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_ans_q <= '0;
            cm_ans_q <= '0;
            ext_we_q <= 1'b0;
            tbl_ok_q <= 1'b0;
        end else if (ce) begin
            cpu_ans_q <= cpu_ans_d;
            cm_ans_q <= cm_ans_d;
            ext_we_q <= ext_we_d;
            tbl_ok_q <= tbl_ok_d;
        end
    end

    // the partition itself has no register here at all
    assign cpu_ans = cpu_ans_q;
    assign cpu_exception = cpu_ans_q.fault;
    assign ext_we = ext_we_q;
    assign cm_ans = cm_ans_q;
    assign cm_busy = cm_state_q[0]; // run is the only state with bit 0 set
    assign tbl_wr_ok = tbl_ok_q;
    assign seg_tbl_addr = seg_q;
    assign seg_enable = seg_en_q;
    assign fw_rights = {fwh_q, fwl_q};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence cpu_acc(smac_mode_t m, logic [7:0] lo, logic [7:0] hi);
        ce && cpu_req.valid && cpu_mode == m && cpu_req.addr >= lo && cpu_req.addr <= hi;
    endsequence

    sequence cm_launch;
        ce && cm_start && cm_state_q == SMAC_CM_IDLE;
    endsequence

    chk_boot_test_deny: assert property (cpu_acc(SMAC_MODE_BOOT, `SMAC_TEST_LO, `SMAC_TEST_HI)
        |=> cpu_ans.fault && cpu_exception) else $error("boot reached test registers");
    chk_test_mode_grant: assert property (cpu_acc(SMAC_MODE_TEST, `SMAC_TEST_LO, `SMAC_TEST_HI)
        |=> cpu_ans.grant) else $error("test mode refused test registers");
    chk_segcfg_user_deny: assert property (cpu_acc(SMAC_MODE_USER, `SMAC_SEG_LO, `SMAC_SEG_HI)
        |=> !cpu_ans.grant ##0 $stable(seg_tbl_addr)) else $error("segment config reached outside system");
    chk_banked_firm_deny: assert property (cpu_acc(SMAC_MODE_FIRM, `SMAC_BANK_LO, `SMAC_BANK_HI)
        |=> cpu_ans.fault) else $error("banked register reached in firmware");
    chk_common_cpu_open: assert property (cpu_acc(SMAC_MODE_USER, `SMAC_CPU_LO, `SMAC_CPU_HI)
        |=> cpu_ans.grant) else $error("common cpu register refused");

    // per-register exceptions
    chk_ptr2_never_read: assert property (ce && cpu_req.valid && !cpu_req.wr
        && cpu_req.addr == `SMAC_ADDR_TBL_PTR2 |=> !cpu_ans.grant && cpu_ans.rdata == 8'h00)
        else $error("second table pointer read back");
    chk_rng_no_write: assert property (ce && cpu_req.valid && cpu_req.wr
        && cpu_req.addr == `SMAC_ADDR_RNG |=> cpu_ans.fault && !ext_we) else $error("random result written");
    chk_key_never_read: assert property (ce && cpu_req.valid && !cpu_req.wr
        && cpu_req.addr >= `SMAC_KEY_LO && cpu_req.addr <= `SMAC_KEY_HI |=> cpu_ans.rdata == 8'h00 && cpu_ans.fault)
        else $error("cipher key read back");

    // copy machine mode latch
    chk_cm_mode_latch: assert property (cm_launch |=> cm_busy && cm_mode_q == $past(cpu_mode))
        else $error("copy machine mode not latched");
    chk_cm_mode_hold: assert property (cm_busy && !cm_done |=> cm_mode_q == $past(cm_mode_q))
        else $error("copy machine mode changed mid run");

    // exceptions and reset defaults
    chk_fault_pairs: assert property (cpu_ans.valid |-> cpu_ans.fault == !cpu_ans.grant)
        else $error("exception and grant disagree");
    chk_seg_reset_zero: assert property (disable iff (1'b0) !rst_n |=> seg_tbl_addr == 16'h0000 && !seg_enable)
        else $error("segment table address not cleared");

    // further mode rules
    chk_firm_os_open: assert property (cpu_acc(SMAC_MODE_FIRM, `SMAC_FWOS_LO, `SMAC_FWOS_HI)
        |=> cpu_ans.grant)
        else $error("firmware refused own registers");
    chk_firm_fwc_ro: assert property (cpu_acc(SMAC_MODE_FIRM, `SMAC_FWC_LO, `SMAC_FWC_HI)
        ##0 cpu_req.wr |=> cpu_ans.fault && $stable(fw_rights))
        else $error("firmware wrote firewall config");
    chk_sys_seg_open: assert property (cpu_acc(SMAC_MODE_SYS, `SMAC_SEG_LO, `SMAC_SEG_HI)
        |=> cpu_ans.grant)
        else $error("system mode refused segment config");
    chk_user_hw_rights: assert property (cpu_acc(SMAC_MODE_USER, `SMAC_ADDR_CLKSEL, `SMAC_ADDR_CLKSEL)
        ##0 !cpu_req.wr ##0 !seg_hw_rd |=> cpu_ans.fault)
        else $error("user read ignored segment rights");
    chk_clksel_firm_rd: assert property (cpu_acc(SMAC_MODE_FIRM, `SMAC_ADDR_CLKSEL, `SMAC_ADDR_CLKSEL)
        ##0 !cpu_req.wr |=> cpu_ans.grant)
        else $error("clock select refused in firmware");
    chk_status_user_rd: assert property (cpu_acc(SMAC_MODE_USER, `SMAC_ADDR_MODE_STATUS, `SMAC_ADDR_MODE_STATUS)
        ##0 !cpu_req.wr |=> cpu_ans.grant && cpu_ans.rdata == {5'h00, $past(cpu_mode)})
        else $error("mode status not readable in user");

    // table writes, reset state and address table
    chk_tbl_user_guard: assert property (ce && tbl_wr_req && cpu_mode == SMAC_MODE_USER
        && !tbl_seg_writable |=> !tbl_wr_ok)
        else $error("user table write passed read-only segment");
    chk_seg_en_tracks: assert property (seg_enable == (seg_tbl_addr != `SMAC_RST_SEG_TBL))
        else $error("segment enable out of step");
    chk_group_known: assert property (ce && cpu_req.valid && cpu_req.addr >= `SMAC_CPU_LO
        |-> cpu_group != SMAC_GRP_NONE)
        else $error("address without access group");
    chk_refused_no_wr: assert property (ce && cpu_req.valid && !cpu_grant
        |=> cpu_exception && !ext_we && !cpu_ans.grant)
        else $error("refused access went through");

endmodule // smac_top

// [logic/smac_cfg.svh]
// constants for the register-space access checker: address map, reset values
// assumes an 8-bit register address space at 0x80..0xFF and 8-bit register data
`ifndef SMAC_CFG_SVH
`define SMAC_CFG_SVH

// group ranges, inclusive bounds
`define SMAC_CPU_LO 8'h80
`define SMAC_CPU_HI 8'h87
`define SMAC_BANK_LO 8'h88
`define SMAC_BANK_HI 8'h8F
`define SMAC_SYS_LO 8'h90
`define SMAC_SYS_HI 8'h97
`define SMAC_SEG_LO 8'h98
`define SMAC_SEG_HI 8'h9F
`define SMAC_FWC_LO 8'hA0
`define SMAC_FWC_HI 8'hA7
`define SMAC_FWOS_LO 8'hA8
`define SMAC_FWOS_HI 8'hAF
`define SMAC_HW_LO 8'hB0
`define SMAC_HW_HI 8'hEF
`define SMAC_TEST_LO 8'hF0
`define SMAC_TEST_HI 8'hFF

// single registers with their own exceptions
`define SMAC_ADDR_MODE_STATUS 8'h90
`define SMAC_ADDR_TBL_PTR2 8'h94
`define SMAC_ADDR_SEG_TBL_LO 8'h98
`define SMAC_ADDR_SEG_TBL_HI 8'h99
`define SMAC_ADDR_FW_LOW 8'hA0
`define SMAC_ADDR_FW_HIGH 8'hA1
`define SMAC_ADDR_CLKSEL 8'hB0
`define SMAC_ADDR_RNG 8'hB8
`define SMAC_KEY_LO 8'hC0
`define SMAC_KEY_HI 8'hCF

// firewall: one rights bit per block of hardware registers
`define SMAC_FW_BLOCK_SHIFT 2

// restrictive reset values, fixed in silicon
`define SMAC_RST_SEG_TBL 16'h0000
`define SMAC_RST_FW_RIGHTS 8'h00
`define SMAC_RST_DATA 8'h00

`endif

// [logic/smac_pkg.sv]
// types shared by the register-space access checker
// assumes smac_cfg.svh for numeric constants
package smac_pkg;

    // cpu operating modes
    typedef enum logic [2:0] {
        SMAC_MODE_BOOT = 3'h0,
        SMAC_MODE_TEST = 3'h1,
        SMAC_MODE_FIRM = 3'h2,
        SMAC_MODE_SYS = 3'h3,
        SMAC_MODE_USER = 3'h4
    } smac_mode_t;

    // access groups of the register space
    typedef enum logic [3:0] {
        SMAC_GRP_NONE = 4'h0,
        SMAC_GRP_CPU = 4'h1,
        SMAC_GRP_BANK = 4'h2,
        SMAC_GRP_SYS = 4'h3,
        SMAC_GRP_SEG = 4'h4,
        SMAC_GRP_FWC = 4'h5,
        SMAC_GRP_FWOS = 4'h6,
        SMAC_GRP_HW = 4'h7,
        SMAC_GRP_TEST = 4'h8
    } smac_group_t;

    // copy machine mode latch
    typedef enum logic [1:0] {
        SMAC_CM_IDLE = 2'b00,
        SMAC_CM_RUN = 2'b01
    } smac_cm_state_t;

    // one register access request
    typedef struct packed {
        logic valid;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smac_req_t;

    // registered verdict for one request
    typedef struct packed {
        logic valid;
        logic grant;
        logic fault;
        logic [7:0] rdata;
    } smac_ans_t;

endpackage

// [logic/smac_check.sv]
// one combinational permission check: address class plus mode rules
// assumes the caller registers the verdict; no state inside
`timescale 1ns/1ns
`include "smac_cfg.svh"

module smac_check
    import smac_pkg::*;
(
    // access under test
    input wire logic [7:0] addr,
    input wire logic is_write,
    input wire smac_mode_t mode,
    // rights sources
    input wire logic [15:0] fw_rights,
    input wire logic seg_rd,
    input wire logic seg_wr,
    // verdict
    output logic grant,
    output smac_group_t group
);

    logic [7:0] hw_off;
    logic fw_bit;
    logic privileged;

    ////////////////////////////////////////////////////////////////////////////
    // hard-wired address table, exactly one group per address
    always_comb begin
        if (addr >= `SMAC_CPU_LO && addr <= `SMAC_CPU_HI) begin
            group = SMAC_GRP_CPU;
        end else if (addr >= `SMAC_BANK_LO && addr <= `SMAC_BANK_HI) begin
            group = SMAC_GRP_BANK;
        end else if (addr >= `SMAC_SYS_LO && addr <= `SMAC_SYS_HI) begin
            group = SMAC_GRP_SYS;
        end else if (addr >= `SMAC_SEG_LO && addr <= `SMAC_SEG_HI) begin
            group = SMAC_GRP_SEG;
        end else if (addr >= `SMAC_FWC_LO && addr <= `SMAC_FWC_HI) begin
            group = SMAC_GRP_FWC;
        end else if (addr >= `SMAC_FWOS_LO && addr <= `SMAC_FWOS_HI) begin
            group = SMAC_GRP_FWOS;
        end else if (addr >= `SMAC_HW_LO && addr <= `SMAC_HW_HI) begin
            group = SMAC_GRP_HW;
        end else if (addr >= `SMAC_TEST_LO) begin
            group = SMAC_GRP_TEST;
        end else begin
            group = SMAC_GRP_NONE; // below the space: always refused
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode rules per group, then per-register exceptions
    always_comb begin
        hw_off = addr - `SMAC_HW_LO;
        fw_bit = fw_rights[hw_off[5:`SMAC_FW_BLOCK_SHIFT]];
        privileged = (mode == SMAC_MODE_BOOT) || (mode == SMAC_MODE_TEST);
        grant = 1'b0;
        case (group)
            SMAC_GRP_CPU: begin
                grant = 1'b1;
            end
            SMAC_GRP_BANK: begin
                grant = (mode == SMAC_MODE_SYS) || (mode == SMAC_MODE_USER);
            end
            SMAC_GRP_TEST: begin
                grant = (mode == SMAC_MODE_TEST);
            end
            SMAC_GRP_SEG: begin
                grant = (mode == SMAC_MODE_SYS);
            end
            SMAC_GRP_SYS: begin
                grant = privileged || (mode == SMAC_MODE_SYS);
                if (addr == `SMAC_ADDR_MODE_STATUS && !is_write &&
                    (mode == SMAC_MODE_FIRM || mode == SMAC_MODE_USER)) begin
                    grant = 1'b1;
                end
                if (addr == `SMAC_ADDR_TBL_PTR2 && !is_write) begin
                    grant = 1'b0;
                end
            end
            SMAC_GRP_FWC: begin
                grant = privileged || (mode == SMAC_MODE_SYS) ||
                        (mode == SMAC_MODE_FIRM && !is_write);
            end
            SMAC_GRP_FWOS: begin
                grant = privileged || (mode == SMAC_MODE_FIRM);
            end
            SMAC_GRP_HW: begin
                case (mode)
                    SMAC_MODE_BOOT, SMAC_MODE_TEST, SMAC_MODE_SYS: begin
                        grant = 1'b1;
                    end
                    SMAC_MODE_FIRM: begin
                        // clock select stays readable whatever the firewall says
                        grant = fw_bit || (addr == `SMAC_ADDR_CLKSEL && !is_write);
                    end
                    SMAC_MODE_USER: begin
                        grant = is_write ? seg_wr : seg_rd;
                    end
                    default: begin
                        grant = 1'b0;
                    end
                endcase
                if (addr == `SMAC_ADDR_RNG && is_write) begin
                    grant = 1'b0;
                end
                if (addr >= `SMAC_KEY_LO && addr <= `SMAC_KEY_HI && !is_write) begin
                    grant = 1'b0;
                end
            end
            default: begin
                grant = 1'b0;
            end
        endcase
    end

endmodule // smac_check

// [sim/smac_ext_regs.sv]
// far-side model: the hardware registers that sit behind the access checker
// assumes cpu_req and ext_we come from the checker on the same clock
`timescale 1ns/1ns

module smac_ext_regs
    import smac_pkg::*;
(
    // clock and enable
    clk,
    ce,
    // register port
    cpu_req,
    ext_we,
    ext_rdata,
    // bookkeeping
    wr_count
);
    input wire logic clk;
    input wire logic ce;
    input wire smac_req_t cpu_req;
    input wire logic ext_we;
    output logic [7:0] ext_rdata;
    output logic [15:0] wr_count;

    logic [7:0] last_q = 8'h00;
    logic [15:0] cnt_q = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // fixed pattern per address; an unaddressed bus shows the inverse of the
    // last value so that a stale read can never match by luck
    always_comb begin
        if (cpu_req.valid) begin
            ext_rdata = cpu_req.addr ^ 8'h5A;
        end else begin
            ext_rdata = ~last_q;
        end
    end

    // count writes that really land here, frozen like the checker when ce is low
    always_ff @(posedge clk) begin
        last_q <= ext_rdata;
        if (ce && ext_we) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign wr_count = cnt_q;
endmodule // smac_ext_regs

// [sim/sfr_mode_access_control_test.sv]
// self-checking bench for the register-space access checker
// assumes smac_top and the far-side model; compares with a bench model
`timescale 1ns/1ns

module sfr_mode_access_control_test
    import smac_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, ce, seg_hw_rd, seg_hw_wr, tbl_wr_req, tbl_seg_writable, cm_start, cm_done;
    logic ext_we, cpu_exception, tbl_wr_ok, cm_busy, seg_enable;
    logic [7:0] ext_rdata;
    logic [15:0] seg_tbl_addr, fw_rights, wr_count, seg_m, fw_m;
    logic [31:0] seed = 32'h7EE711DB;
    smac_req_t cpu_req, cm_req;
    smac_mode_t cpu_mode;
    smac_ans_t cpu_ans, cm_ans;
    int err_total = 0;
    int check_count = 0;
    int nwr = 0;
    int addrs[20] = '{'h70, 'h80, 'h87, 'h88, 'h8F, 'h90, 'h94, 'h98, 'h99, 'hA0,
                      'hA1, 'hA5, 'hA8, 'hB0, 'hB4, 'hB8, 'hC0, 'hCF, 'hEC, 'hF0};

    always #20 clk = ~clk;

    smac_top smac_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .cpu_req(cpu_req), .cpu_mode(cpu_mode),
        .seg_hw_rd(seg_hw_rd), .seg_hw_wr(seg_hw_wr), .ext_rdata(ext_rdata), .cpu_ans(cpu_ans),
        .ext_we(ext_we), .cpu_exception(cpu_exception), .tbl_wr_req(tbl_wr_req),
        .tbl_seg_writable(tbl_seg_writable), .tbl_wr_ok(tbl_wr_ok), .cm_start(cm_start),
        .cm_done(cm_done), .cm_req(cm_req), .cm_ans(cm_ans), .cm_busy(cm_busy),
        .seg_tbl_addr(seg_tbl_addr), .seg_enable(seg_enable), .fw_rights(fw_rights));

    smac_ext_regs smac_ext_regs_inst (.clk(clk), .ce(ce), .cpu_req(cpu_req), .ext_we(ext_we),
        .ext_rdata(ext_rdata), .wr_count(wr_count));

    ////////////////////////////////////////////////////////////////////////////////
    // bench model: mode 0 boot, 1 test, 2 firmware, 3 system, 4 user
    function automatic bit allow(int m, int a, bit w, bit hr, bit hw);
        bit bt = (m < 2);
        if (a < 'h80) return 0;
        if (a < 'h88) return 1;
        if (a < 'h90) return m >= 3;
        if (a < 'h98) return !(a == 'h94 && !w) && (bt || m == 3 || (a == 'h90 && !w && m != 3));
        if (a < 'hA0) return m == 3;
        if (a < 'hA8) return bt || m == 3 || (m == 2 && !w);
        if (a < 'hB0) return m <= 2;
        if (a >= 'hF0) return m == 1;
        if (w && a == 'hB8) return 0;
        if (!w && a >= 'hC0 && a <= 'hCF) return 0;
        if (m == 2) return fw_m[(a - 'hB0) >> 2] || (a == 'hB0 && !w);
        if (m == 4) return w ? hw : hr;
        return 1;
    endfunction

    // read data of registers held inside the checker, else the far-side pattern
    function automatic logic [7:0] exp_rd(int m, int a);
        case (a)
            'h90: return {5'h00, m[2:0]};
            'h98: return seg_m[7:0];
            'h99: return seg_m[15:8];
            'hA0: return fw_m[7:0];
            'hA1: return fw_m[15:8];
            default: return a[7:0] ^ 8'h5A;
        endcase
    endfunction

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, test end and verdict
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic fin(input string n);
        $display("test %s done: %0d checks, %0d mismatches", n, check_count, err_total);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one cpu access, driven at the falling edge and judged after the next rise
    task automatic access(int m, bit w, int a, logic [7:0] d, bit hr, bit hw);
        bit g;
        logic [7:0] er;
        @(negedge clk);
        cpu_mode = smac_mode_t'(m[2:0]);
        cpu_req = '{1'b1, w, a[7:0], d};
        seg_hw_rd = hr;
        seg_hw_wr = hw;
        g = allow(m, a, w, hr, hw);
        er = (g && !w) ? exp_rd(m, a) : 8'h00;
        @(posedge clk);
        #1;
        compare({cpu_ans.valid, cpu_ans.grant, cpu_ans.fault}, {1'b1, g, !g});
        compare(cpu_exception, !g);
        if (!w || !g) begin
            compare(cpu_ans.rdata, er);
        end
        compare(ext_we, g && w && a != 'h98 && a != 'h99 && a != 'hA0 && a != 'hA1);
        if (g && w) begin
            case (a)
                'h98: seg_m[7:0] = d;
                'h99: seg_m[15:8] = d;
                'hA0: fw_m[7:0] = d;
                'hA1: fw_m[15:8] = d;
                default: nwr++;
            endcase
        end
        compare(seg_tbl_addr, seg_m);
        compare(seg_enable, seg_m != 16'h0000);
        compare(fw_rights, fw_m);
    endtask

    // one copy machine read, judged with the mode latched at its start
    task automatic cm_read(int a, int lm, bit busy, bit dn);
        bit g;
        @(negedge clk);
        cm_req = '{1'b1, 1'b0, a[7:0], 8'h00};
        cm_done = dn;
        g = busy && allow(lm, a, 1'b0, seg_hw_rd, seg_hw_wr);
        @(posedge clk);
        #1;
        compare({cm_ans.valid, cm_ans.grant, cm_ans.fault, cm_ans.rdata}, {1'b1, g, !g, 8'h00});
    endtask

    task automatic idle();
        @(negedge clk);
        cpu_req.valid = 1'b0;
        cm_req.valid = 1'b0;
        cm_start = 1'b0;
        cm_done = 1'b0;
        tbl_wr_req = 1'b0;
        ce = 1'b1;
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        seg_m = 16'h0000;
        fw_m = 16'h0000;
        compare(seg_tbl_addr, 16'h0000);
        compare({seg_enable, cm_busy, cpu_ans}, 13'h0000);
        compare(fw_rights, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // run limit
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        {ce, seg_hw_rd, seg_hw_wr, tbl_wr_req, tbl_seg_writable, cm_start, cm_done} = 7'h40;
        rst_n = 1'b0;
        cpu_req = '0;
        cm_req = '0;
        cpu_mode = SMAC_MODE_BOOT;
        do_reset();
        fin("reset");
        // every mode against every address class, read and write; the system class is only read
        foreach (addrs[i]) begin
            for (int m = 0; m < 5; m++) begin
                for (int w = 0; w < 2; w++) begin
                    r = rnd();
                    access(m, w == 1 && addrs[i] != 'h90 && addrs[i] != 'h94, addrs[i], r[7:0], r[8], r[9]);
                end
            end
        end
        idle();
        fin("matrix");
        // random back-to-back traffic, firewall and table bytes change on the way
        repeat (500) begin
            r = rnd();
            access(r[2:0] % 5, r[8] && r[16:12] % 20 != 5 && r[16:12] % 20 != 6, addrs[r[16:12] % 20], r[31:24], r[9], r[10]);
        end
        idle();
        @(negedge clk);
        compare(wr_count, nwr[15:0]);
        fin("random");
        // copy machine: idle refusal, latched mode, restart ignored, done
        cm_read('h80, 3, 1'b0, 1'b0);
        idle();
        @(negedge clk);
        cm_start = 1'b1;
        cpu_mode = SMAC_MODE_FIRM;
        @(negedge clk);
        cm_start = 1'b0;
        cpu_mode = SMAC_MODE_SYS;
        compare(cm_busy, 1'b1);
        cm_read('h88, 2, 1'b1, 1'b0);
        cm_read('h98, 2, 1'b1, 1'b0);
        @(negedge clk);
        cm_req.valid = 1'b0;
        cm_start = 1'b1;
        cpu_mode = SMAC_MODE_USER;
        @(negedge clk);
        cm_start = 1'b0;
        cm_read('hA8, 2, 1'b1, 1'b1);
        compare(cm_busy, 1'b0);
        idle();
        fin("copy machine");
        // segment table writes from every mode, writable and read-only segment
        for (int m = 0; m < 5; m++) begin
            for (int s = 0; s < 2; s++) begin
                @(negedge clk);
                tbl_wr_req = 1'b1;
                tbl_seg_writable = s[0];
                cpu_mode = smac_mode_t'(m[2:0]);
                @(posedge clk);
                #1;
                compare(tbl_wr_ok, m != 4 || s == 1);
            end
        end
        idle();
        fin("table write");
        // frozen enable: a write while ce is low must not land
        access(3, 1'b1, 'hA0, 8'h33, 1'b0, 1'b0);
        @(negedge clk);
        ce = 1'b0;
        cpu_req = '{1'b1, 1'b1, 8'hA0, 8'h77};
        repeat (2) @(posedge clk);
        #1;
        compare(fw_rights, fw_m);
        idle();
        @(posedge clk);
        #1;
        compare(cpu_ans.valid, 1'b0);
        // table address set, then a second reset brings back the closed defaults
        access(3, 1'b1, 'h99, 8'hC3, 1'b0, 1'b0);
        idle();
        do_reset();
        fin("enable and reset");
        results();
    end
endmodule // sfr_mode_access_control_test
